// ==== mgp_gpio.sv ====
`timescale 1ns/1ps
// What this block does
// - After reset every GPIO pin is input
// - Wake and PWM data registers always accessible; directions where present
// - Direction 1 output, 0 input, reset zero
// - Address/data port registers hidden outside single-chip
// - Address/data pull-ups on inputs, not expanded
// - Reduced-drive register write-once, hidden in peripheral
// - Bus-control pins 1:0 input-only, readable only while bus-control registers visible
// - Pin-function overrides direction; only bits 7:2 work
// - Bus-control pull-up on pins 7 and 3:0
// - Bus-control registers hidden peripheral or emulated expanded
// - Falling edge sets wake flag; enable gates interrupt
// - Wake port pull select low down, high up
// - CAN transmit 0 dominant, 1 recessive
// - CAN receive bit 0, transmit bit 1
// - Analog ports are eight inputs when converter off
// - Enabled PWM channel overrides general-purpose pin
// - PWM port pull-up enable, reset disabled
// - PWM port reduced drive, reset full, read/write
module mgp_gpio
  import mgp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  op_mode,
  input  wire logic        ext_bus_ctrl_emulation,
  input  wire logic [7:0]  bus_ctrl_pin_function,
  input  wire logic        converter0_power_up,
  input  wire logic        converter1_power_up,
  input  wire logic [3:0]  pwm_channel_enable,
  input  wire logic [3:0]  pwm_wave,
  input  wire logic        can_tx_dominant,
  output logic             can_rx_level,
  input  wire logic        pull_select_one,
  input  wire logic        pull_select_two,
  input  wire logic [7:0]  addr_lo_in,
  input  wire logic [7:0]  addr_hi_in,
  input  wire logic [7:0]  bus_ctrl_in,
  input  wire logic [7:0]  wake_one_in,
  input  wire logic [7:0]  wake_two_in,
  input  wire logic [7:0]  pwm_port_in,
  input  wire logic        can_rx_pin,
  input  wire logic [7:0]  analog_port0_inputs,
  input  wire logic [7:0]  analog_port1_inputs,
  output logic      [7:0]  addr_lo_out,
  output logic      [7:0]  addr_lo_oe_n,
  output logic      [7:0]  addr_hi_out,
  output logic      [7:0]  addr_hi_oe_n,
  output logic      [7:0]  bus_ctrl_out,
  output logic      [7:0]  bus_ctrl_oe_n,
  output logic      [7:0]  wake_one_out,
  output logic      [7:0]  wake_one_oe_n,
  output logic      [7:0]  wake_two_out,
  output logic      [7:0]  wake_two_oe_n,
  output logic      [7:0]  pwm_port_out,
  output logic      [7:0]  pwm_port_oe_n,
  output logic             can_tx_pin,
  output logic      [7:0]  pull_up_en_lo,
  output logic      [7:0]  pull_up_en_hi,
  output logic      [7:0]  pull_up_en_bus,
  output logic      [7:0]  pull_en_wake_one,
  output logic      [7:0]  pull_en_wake_two,
  output logic             pull_dir_up_one,
  output logic             pull_dir_up_two,
  output logic      [7:0]  pull_up_en_pwm,
  output logic      [5:0]  low_drive,
  output logic             irq
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [7:0] sync_level(input logic [7:0] s2, input logic [7:0] s3,
                                            input logic [7:0] cur);
    sync_level = ((s2 ^ s3) & cur) | (~(s2 ^ s3) & s3);
  endfunction : sync_level

  function automatic logic [7:0] mix_read(input logic [7:0] dir, input logic [7:0] lat,
                                          input logic [7:0] pin);
    mix_read = (dir & lat) | (~dir & pin);
  endfunction : mix_read

  function automatic logic [7:0] w1c(input logic [7:0] flags, input logic [7:0] clr,
                                     input logic [7:0] set);
    w1c = (flags & ~clr) | set;
  endfunction : w1c

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 65;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] level;
  assign raw_in = {analog_port1_inputs, analog_port0_inputs, can_rx_pin, pwm_port_in,
                   wake_two_in, wake_one_in, bus_ctrl_in, addr_hi_in, addr_lo_in};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < NSYNC; i++) begin
        if (sync2[i] == sync3[i]) begin
          level[i] <= sync3[i];
        end
      end
    end
  end

  logic [7:0] lv_lo;
  logic [7:0] lv_hi;
  logic [7:0] lv_bus;
  logic [7:0] lv_w1;
  logic [7:0] lv_w2;
  logic [7:0] lv_pwm;
  logic [7:0] lv_an0;
  logic [7:0] lv_an1;
  logic       lv_can;
  assign lv_lo  = level[7:0];
  assign lv_hi  = level[15:8];
  assign lv_bus = level[23:16];
  assign lv_w1  = level[31:24];
  assign lv_w2  = level[39:32];
  assign lv_pwm = level[47:40];
  assign lv_can = level[48];
  assign lv_an0 = level[56:49];
  assign lv_an1 = level[64:57];

  // ****************************************
  // Mode decode and bus decode
  // ****************************************
  logic single_chip;
  logic expanded;
  logic peripheral;
  assign single_chip = (op_mode == MGP_SINGLE_CHIP);
  assign expanded    = (op_mode == MGP_EXPANDED);
  assign peripheral  = (op_mode == MGP_PERIPHERAL);

  logic addr_vis;
  logic bus_vis;
  logic drv_vis;
  assign addr_vis = single_chip;
  assign bus_vis  = !peripheral && !(expanded && ext_bus_ctrl_emulation);
  assign drv_vis  = !peripheral;

  logic       wr;
  logic [7:0] wd;
  assign wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wd = avs_writedata[7:0];

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] lo_data, lo_dir, hi_data, hi_dir, bus_data, bus_dir;
  logic [7:0] w1_data, w1_dir, w2_data, w2_dir, pwm_data, pwm_dir;
  logic [7:0] w1_ien, w2_ien, pull_enable_reg, reduced_drive_reg;
  logic [1:0] pwm_port_control;
  logic       drv_written;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lo_data  <= RST_BYTE;
      hi_data  <= RST_BYTE;
      bus_data <= RST_BYTE;
      w1_data  <= RST_BYTE;
      w2_data  <= RST_BYTE;
      pwm_data <= RST_BYTE;
    end else if (wr) begin
      if (avs_address == OFS_ADDR_LO_DATA && addr_vis) begin
        lo_data <= wd;
      end else if (avs_address == OFS_ADDR_HI_DATA && addr_vis) begin
        hi_data <= wd;
      end else if (avs_address == OFS_BUS_DATA && bus_vis) begin
        bus_data <= wd;
      end else if (avs_address == OFS_WAKE1_DATA) begin
        w1_data <= wd;
      end else if (avs_address == OFS_WAKE2_DATA) begin
        w2_data <= wd;
      end else if (avs_address == OFS_PWM_DATA) begin
        pwm_data <= wd;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lo_dir  <= RST_BYTE;
      hi_dir  <= RST_BYTE;
      bus_dir <= RST_BYTE;
      w1_dir  <= RST_BYTE;
      w2_dir  <= RST_BYTE;
      pwm_dir <= RST_BYTE;
    end else if (wr) begin
      if (avs_address == OFS_ADDR_LO_DIR && addr_vis) begin
        lo_dir <= wd;
      end else if (avs_address == OFS_ADDR_HI_DIR && addr_vis) begin
        hi_dir <= wd;
      end else if (avs_address == OFS_BUS_DIR && bus_vis) begin
        bus_dir <= wd & BUS_CTRL_DIR_MASK;
      end else if (avs_address == OFS_WAKE1_DIR) begin
        w1_dir <= wd;
      end else if (avs_address == OFS_WAKE2_DIR) begin
        w2_dir <= wd;
      end else if (avs_address == OFS_PWM_DIR) begin
        pwm_dir <= wd;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pull_enable_reg  <= RST_BYTE;
      w1_ien           <= RST_BYTE;
      w2_ien           <= RST_BYTE;
      pwm_port_control <= 2'h0;
    end else if (wr) begin
      if (avs_address == OFS_PULL_EN) begin
        pull_enable_reg <= wd;
      end else if (avs_address == OFS_WAKE1_IEN) begin
        w1_ien <= wd;
      end else if (avs_address == OFS_WAKE2_IEN) begin
        w2_ien <= wd;
      end else if (avs_address == OFS_PWM_CTRL) begin
        pwm_port_control <= wd[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reduced_drive_reg <= RST_BYTE;
      drv_written       <= 1'b0;
    end else if (wr && avs_address == OFS_REDUCED && drv_vis && !drv_written) begin
      reduced_drive_reg <= wd;
      drv_written       <= 1'b1;
    end
  end

  // ****************************************
  // Key wake-up flags
  // ****************************************
  logic [7:0] w1_prev, w2_prev, wake_flags_one, wake_flags_two;
  logic [7:0] clr1, clr2;
  assign clr1 = (wr && avs_address == OFS_WAKE1_FLAGS) ? wd : 8'h00;
  assign clr2 = (wr && avs_address == OFS_WAKE2_FLAGS) ? wd : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w1_prev        <= RST_BYTE;
      w2_prev        <= RST_BYTE;
      wake_flags_one <= RST_BYTE;
      wake_flags_two <= RST_BYTE;
    end else begin
      w1_prev        <= lv_w1;
      w2_prev        <= lv_w2;
      wake_flags_one <= w1c(wake_flags_one, clr1, w1_prev & ~lv_w1);
      wake_flags_two <= w1c(wake_flags_two, clr2, w2_prev & ~lv_w2);
    end
  end

  // ****************************************
  // Bus read and handshake
  // ****************************************
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    if (avs_address == OFS_ADDR_LO_DATA && addr_vis) begin
      rd = mix_read(lo_dir, lo_data, lv_lo);
    end else if (avs_address == OFS_ADDR_HI_DATA && addr_vis) begin
      rd = mix_read(hi_dir, hi_data, lv_hi);
    end else if (avs_address == OFS_ADDR_LO_DIR && addr_vis) begin
      rd = lo_dir;
    end else if (avs_address == OFS_ADDR_HI_DIR && addr_vis) begin
      rd = hi_dir;
    end else if (avs_address == OFS_BUS_DATA && bus_vis) begin
      rd = mix_read(bus_dir, bus_data, lv_bus);
    end else if (avs_address == OFS_BUS_DIR && bus_vis) begin
      rd = bus_dir;
    end else if (avs_address == OFS_PIN_FUNC) begin
      rd = bus_ctrl_pin_function;
    end else if (avs_address == OFS_PULL_EN) begin
      rd = pull_enable_reg;
    end else if (avs_address == OFS_REDUCED && drv_vis) begin
      rd = reduced_drive_reg;
    end else if (avs_address == OFS_WAKE1_DATA) begin
      rd = mix_read(w1_dir, w1_data, lv_w1);
    end else if (avs_address == OFS_WAKE1_DIR) begin
      rd = w1_dir;
    end else if (avs_address == OFS_WAKE1_FLAGS) begin
      rd = wake_flags_one;
    end else if (avs_address == OFS_WAKE1_IEN) begin
      rd = w1_ien;
    end else if (avs_address == OFS_WAKE2_DATA) begin
      rd = mix_read(w2_dir, w2_data, lv_w2);
    end else if (avs_address == OFS_WAKE2_DIR) begin
      rd = w2_dir;
    end else if (avs_address == OFS_WAKE2_FLAGS) begin
      rd = wake_flags_two;
    end else if (avs_address == OFS_WAKE2_IEN) begin
      rd = w2_ien;
    end else if (avs_address == OFS_PWM_DATA) begin
      rd = mix_read(pwm_dir, pwm_data, lv_pwm);
    end else if (avs_address == OFS_PWM_DIR) begin
      rd = pwm_dir;
    end else if (avs_address == OFS_PWM_CTRL) begin
      rd = {6'h00, pwm_port_control};
    end else if (avs_address == OFS_CAN_DATA) begin
      rd = {6'h00, !can_tx_dominant, lv_can};
    end else if (avs_address == OFS_AN0_DATA && !converter0_power_up) begin
      rd = lv_an0;
    end else if (avs_address == OFS_AN1_DATA && !converter1_power_up) begin
      rd = lv_an1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= UNMAPPED_READ;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {24'h000000, rd};
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  logic [7:0] bus_oe;
  logic [7:0] pwm_sel;
  assign bus_oe  = bus_dir & ~bus_ctrl_pin_function & BUS_CTRL_DIR_MASK;
  assign pwm_sel = {4'h0, pwm_channel_enable};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_lo_out   <= 8'h00;
      addr_lo_oe_n  <= 8'hFF;
      addr_hi_out   <= 8'h00;
      addr_hi_oe_n  <= 8'hFF;
      bus_ctrl_out  <= 8'h00;
      bus_ctrl_oe_n <= 8'hFF;
      wake_one_out  <= 8'h00;
      wake_one_oe_n <= 8'hFF;
      wake_two_out  <= 8'h00;
      wake_two_oe_n <= 8'hFF;
      pwm_port_out  <= 8'h00;
      pwm_port_oe_n <= 8'hFF;
      can_tx_pin    <= 1'b1;
      can_rx_level  <= 1'b1;
    end else begin
      addr_lo_out   <= lo_data;
      addr_lo_oe_n  <= single_chip ? ~lo_dir : 8'hFF;
      addr_hi_out   <= hi_data;
      addr_hi_oe_n  <= single_chip ? ~hi_dir : 8'hFF;
      bus_ctrl_out  <= bus_data;
      bus_ctrl_oe_n <= ~bus_oe;
      wake_one_out  <= w1_data;
      wake_one_oe_n <= ~w1_dir;
      wake_two_out  <= w2_data;
      wake_two_oe_n <= ~w2_dir;
      pwm_port_out  <= (pwm_sel & {4'h0, pwm_wave}) | (~pwm_sel & pwm_data);
      pwm_port_oe_n <= ~(pwm_sel | pwm_dir);
      can_tx_pin    <= !can_tx_dominant;
      can_rx_level  <= lv_can;
    end
  end

  // ****************************************
  // Pulls, drive strength, interrupt
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pull_up_en_lo    <= 8'h00;
      pull_up_en_hi    <= 8'h00;
      pull_up_en_bus   <= 8'h00;
      pull_en_wake_one <= 8'h00;
      pull_en_wake_two <= 8'h00;
      pull_dir_up_one  <= 1'b0;
      pull_dir_up_two  <= 1'b0;
      pull_up_en_pwm   <= 8'h00;
      low_drive        <= 6'h00;
      irq              <= 1'b0;
    end else begin
      pull_up_en_lo  <= (pull_enable_reg[PULL_BIT_ADDR_LO] && !expanded) ? ~lo_dir : 8'h00;
      pull_up_en_hi  <= (pull_enable_reg[PULL_BIT_ADDR_HI] && !expanded) ? ~hi_dir : 8'h00;
      pull_up_en_bus <= pull_enable_reg[PULL_BIT_BUS_CTRL] ? BUS_CTRL_PULL_MASK : 8'h00;
      pull_en_wake_one <= pull_enable_reg[PULL_BIT_WAKE_ONE] ? ~w1_dir : 8'h00;
      pull_en_wake_two <= pull_enable_reg[PULL_BIT_WAKE_TWO] ? ~w2_dir : 8'h00;
      pull_dir_up_one  <= pull_select_one;
      pull_dir_up_two  <= pull_select_two;
      pull_up_en_pwm <= pwm_port_control[PWMC_BIT_PULL] ? ~(pwm_dir | pwm_sel) : 8'h00;
      low_drive <= {pwm_port_control[PWMC_BIT_DRIVE],
                    reduced_drive_reg[DRV_BIT_WAKE_TWO], reduced_drive_reg[DRV_BIT_WAKE_ONE],
                    reduced_drive_reg[DRV_BIT_BUS_CTRL], reduced_drive_reg[DRV_BIT_ADDR_HI],
                    reduced_drive_reg[DRV_BIT_ADDR_LO]};
      irq <= |(wake_flags_one & w1_ien) || |(wake_flags_two & w2_ien);
    end
  end
endmodule : mgp_gpio

// ==== mgp_gpio_checker.sv ====
`timescale 1ns/1ps
// ********
// Pin and bus checks
// ********
module mgp_gpio_checker
  import mgp_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [1:0] op_mode,
  input wire logic [7:0] bus_ctrl_pin_function,
  input wire logic [3:0] pwm_channel_enable,
  input wire logic [3:0] pwm_wave,
  input wire logic       can_tx_dominant,
  input wire logic       can_tx_pin,
  input wire logic [7:0] addr_lo_oe_n,
  input wire logic [7:0] addr_hi_oe_n,
  input wire logic [7:0] bus_ctrl_oe_n,
  input wire logic [7:0] pwm_port_oe_n,
  input wire logic [7:0] pwm_port_out,
  input wire logic [7:0] pull_up_en_bus
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_reset_inputs: assert property ($rose(resetn) |->
    &{addr_lo_oe_n, addr_hi_oe_n, bus_ctrl_oe_n, pwm_port_oe_n}) else $error("pin driven at reset");
  a_bus_in_only: assert property (bus_ctrl_oe_n[1:0] == 2'b11)
    else $error("input-only pin driven");
  a_func_override: assert property ($stable(bus_ctrl_pin_function) |->
    (bus_ctrl_pin_function & ~bus_ctrl_oe_n) == 8'h00) else $error("function pin driven");
  a_addr_hidden: assert property (op_mode != MGP_SINGLE_CHIP && $past(op_mode) != MGP_SINGLE_CHIP
    |-> &{addr_lo_oe_n, addr_hi_oe_n}) else $error("address port driven");
  a_can_tx_level: assert property ($past(resetn) |-> can_tx_pin == !$past(can_tx_dominant))
    else $error("transmit level wrong");
  a_pwm_wins: assert property ($past(resetn) && $past(pwm_channel_enable[0]) |->
    !pwm_port_oe_n[0] && pwm_port_out[0] == $past(pwm_wave[0])) else $error("pwm not on pin");
  a_bus_pull_pins: assert property ((pull_up_en_bus & 8'h70) == 8'h00)
    else $error("pull on wrong pin");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one cycle");
endmodule : mgp_gpio_checker

bind mgp_gpio mgp_gpio_checker mgp_gpio_checker_inst (.clk, .resetn, .avs_read, .avs_write,
  .avs_waitrequest, .op_mode, .bus_ctrl_pin_function, .pwm_channel_enable, .pwm_wave,
  .can_tx_dominant, .can_tx_pin, .addr_lo_oe_n, .addr_hi_oe_n, .bus_ctrl_oe_n, .pwm_port_oe_n,
  .pwm_port_out, .pull_up_en_bus);

// ==== mgp_gpio_tb.sv ====
`timescale 1ns/1ps
module mgp_gpio_tb
  import mgp_pkg::*;
;
  logic clk = 1'b0;
  logic resetn, avs_read, avs_write, ext_bus_ctrl_emulation, converter0_power_up, can_rx_pin;
  logic converter1_power_up, can_tx_dominant, pull_select_one, pull_select_two;
  logic [7:0] avs_address, bus_ctrl_pin_function, ext_level, analog_port0_inputs;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, pwm_channel_enable, pwm_wave;
  logic [1:0] op_mode;
  logic avs_waitrequest, can_rx_level, can_tx_pin, pull_dir_up_one, pull_dir_up_two, irq;
  wire logic [7:0] addr_lo_in, bus_ctrl_in, wake_one_in, wake_two_in, pwm_port_in;
  logic [7:0] addr_lo_out, addr_lo_oe_n, addr_hi_out, addr_hi_oe_n, bus_ctrl_out, bus_ctrl_oe_n;
  logic [7:0] wake_one_out, wake_one_oe_n, wake_two_out, wake_two_oe_n, pwm_port_out, pwm_port_oe_n;
  logic [7:0] pull_up_en_lo, pull_up_en_hi, pull_up_en_bus, pull_en_wake_one, pull_en_wake_two;
  logic [7:0] pull_up_en_pwm;
  logic [5:0] low_drive;
  int error_cnt = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  mgp_gpio mgp_gpio_inst (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .op_mode, .ext_bus_ctrl_emulation,
    .bus_ctrl_pin_function, .converter0_power_up, .converter1_power_up, .pwm_channel_enable,
    .pwm_wave, .can_tx_dominant, .can_rx_level, .pull_select_one, .pull_select_two, .addr_lo_in,
    .addr_hi_in(ext_level), .bus_ctrl_in, .wake_one_in, .wake_two_in, .pwm_port_in, .can_rx_pin,
    .analog_port0_inputs, .analog_port1_inputs(analog_port0_inputs), .addr_lo_out, .addr_lo_oe_n,
    .addr_hi_out, .addr_hi_oe_n, .bus_ctrl_out, .bus_ctrl_oe_n, .wake_one_out, .wake_one_oe_n,
    .wake_two_out, .wake_two_oe_n, .pwm_port_out, .pwm_port_oe_n, .can_tx_pin, .pull_up_en_lo,
    .pull_up_en_hi, .pull_up_en_bus, .pull_en_wake_one, .pull_en_wake_two, .pull_dir_up_one,
    .pull_dir_up_two, .pull_up_en_pwm, .low_drive, .irq);
  mgp_pin_model mgp_pin_model_inst (
    .pin_out  ({pwm_port_out, wake_two_out, wake_one_out, bus_ctrl_out, addr_lo_out}),
    .pin_oe_n ({pwm_port_oe_n, wake_two_oe_n, wake_one_oe_n, bus_ctrl_oe_n, addr_lo_oe_n}),
    .pull_en  ({pull_up_en_pwm, pull_en_wake_two, pull_en_wake_one, pull_up_en_bus, pull_up_en_lo}),
    .pull_up  ({1'b1, pull_dir_up_two, pull_dir_up_one, 1'b1, 1'b1}),
    .ext_level(ext_level),
    .pin_in   ({pwm_port_in, wake_two_in, wake_one_in, bus_ctrl_in, addr_lo_in}));
  // ********
  // Shared tasks
  // ********
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        error_cnt++;
        print_verdict();
      end
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, e);
  endtask : rd
  // ********
  // Scenarios
  // ********
  task automatic t_reset_vals();
    logic [7:0] ofs [9] = '{OFS_ADDR_LO_DIR, OFS_ADDR_HI_DIR, OFS_BUS_DIR, OFS_WAKE1_DIR,
                           OFS_WAKE2_DIR, OFS_PWM_DIR, OFS_PULL_EN, OFS_PWM_CTRL, OFS_REDUCED};
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(8'hFC, 8'h00);
    check(pwm_port_oe_n & wake_one_oe_n, 8'hFF);
  endtask : t_reset_vals
  task automatic t_dir_data();
    ext_level <= 8'h3C;
    wr(OFS_ADDR_LO_DIR, 8'hF0);
    wr(OFS_ADDR_LO_DATA, 8'hA5);
    cyc(8);
    check(addr_lo_oe_n, 8'h0F);
    check(addr_lo_out & 8'hF0, 8'hA0);
    rd(OFS_ADDR_LO_DATA, 8'hAC);
    ext_level <= 8'h00;
    wr(OFS_PULL_EN, 8'h01);
    cyc(8);
    rd(OFS_ADDR_LO_DATA, 8'hAF);
    wr(OFS_PULL_EN, 8'h00);
    wr(OFS_BUS_DIR, 8'h0C);
    op_mode <= MGP_EXPANDED;
    ext_bus_ctrl_emulation <= 1'b1;
    wr(OFS_ADDR_LO_DIR, 8'h00);
    rd(OFS_ADDR_LO_DATA, 8'h00);
    rd(OFS_BUS_DIR, 8'h00);
    op_mode <= MGP_PERIPHERAL;
    ext_bus_ctrl_emulation <= 1'b0;
    rd(OFS_BUS_DIR, 8'h00);
    op_mode <= MGP_SINGLE_CHIP;
    rd(OFS_ADDR_LO_DIR, 8'hF0);
    rd(OFS_BUS_DIR, 8'h0C);
  endtask : t_dir_data
  task automatic t_bus_ctrl();
    wr(OFS_BUS_DIR, 8'hFF);
    rd(OFS_BUS_DIR, 8'hFC);
    wr(OFS_BUS_DATA, 8'h50);
    ext_level <= 8'h02;
    cyc(8);
    check(bus_ctrl_oe_n, 8'h03);
    rd(OFS_BUS_DATA, 8'h52);
    bus_ctrl_pin_function <= 8'h30;
    cyc(3);
    check(bus_ctrl_oe_n, 8'h33);
    bus_ctrl_pin_function <= 8'h00;
    wr(OFS_BUS_DIR, 8'h00);
    wr(OFS_REDUCED, 8'h11);
    wr(OFS_REDUCED, 8'h02);
    rd(OFS_REDUCED, 8'h11);
    check({2'b00, low_drive}, 8'h05);
  endtask : t_bus_ctrl
  task automatic t_wake();
    ext_level <= 8'hFF;
    wr(OFS_WAKE2_DATA, 8'hFF);
    wr(OFS_WAKE2_DIR, 8'hFF);
    cyc(8);
    wr(OFS_WAKE1_FLAGS, 8'hFF);
    wr(OFS_WAKE2_FLAGS, 8'hFF);
    ext_level <= 8'h00;
    wr(OFS_WAKE2_DATA, 8'h7E);
    cyc(8);
    rd(OFS_WAKE1_FLAGS, 8'hFF);
    rd(OFS_WAKE2_FLAGS, 8'h81);
    check({7'h00, irq}, 8'h00);
    wr(OFS_WAKE1_IEN, 8'h01);
    cyc(2);
    check({7'h00, irq}, 8'h01);
    wr(OFS_WAKE1_FLAGS, 8'h01);
    cyc(2);
    check({7'h00, irq}, 8'h00);
    rd(OFS_WAKE1_FLAGS, 8'hFE);
    wr(OFS_PULL_EN, 8'h20);
    cyc(8);
    rd(OFS_WAKE1_DATA, 8'h00);
    pull_select_one <= 1'b1;
    cyc(8);
    rd(OFS_WAKE1_DATA, 8'hFF);
  endtask : t_wake
  task automatic t_side_ports();
    can_rx_pin <= 1'b1;
    can_tx_dominant <= 1'b1;
    analog_port0_inputs <= 8'h5A;
    cyc(8);
    check({7'h00, can_tx_pin}, 8'h00);
    rd(OFS_CAN_DATA, 8'h01);
    check({7'h00, can_rx_level}, 8'h01);
    rd(OFS_AN0_DATA, 8'h5A);
    rd(OFS_AN1_DATA, 8'h5A);
    converter0_power_up <= 1'b1;
    rd(OFS_AN0_DATA, 8'h00);
    pwm_channel_enable <= 4'h1;
    pwm_wave <= 4'h1;
    wr(OFS_PWM_CTRL, 8'h03);
    rd(OFS_PWM_CTRL, 8'h03);
    check(pwm_port_oe_n, 8'hFE);
    check({2'b00, low_drive} & 8'h20, 8'h20);
    check(pull_up_en_pwm & 8'hFE, 8'hFE);
    pwm_channel_enable <= 4'h0;
  endtask : t_side_ports
  initial begin
    {resetn, avs_read, avs_write, ext_bus_ctrl_emulation, converter0_power_up} = 5'h00;
    {converter1_power_up, can_tx_dominant, pull_select_one, pull_select_two, can_rx_pin} = 5'h00;
    {avs_address, bus_ctrl_pin_function, ext_level, analog_port0_inputs} = 32'h00000000;
    {avs_writedata, pwm_channel_enable, pwm_wave, op_mode} = 42'h00000000000;
    avs_byteenable = 4'hF;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    cyc(2);
    t_reset_vals();
    t_dir_data();
    t_bus_ctrl();
    t_wake();
    t_side_ports();
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    cyc(2);
    t_reset_vals();
    print_verdict();
  end
endmodule : mgp_gpio_tb

// ==== mgp_pin_model.sv ====
`timescale 1ns/1ps
// ********
// Board pins: driver, pull load, else bench level
// ********
module mgp_pin_model (
  input  wire logic [4:0][7:0] pin_out,
  input  wire logic [4:0][7:0] pin_oe_n,
  input  wire logic [4:0][7:0] pull_en,
  input  wire logic [4:0]      pull_up,
  input  wire logic [7:0]      ext_level,
  output logic      [4:0][7:0] pin_in
);
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (!pin_oe_n[p][b]) pin_in[p][b] = pin_out[p][b];
        else if (pull_en[p][b]) pin_in[p][b] = pull_up[p];
        else pin_in[p][b] = ext_level[b];
      end
    end
  end
endmodule : mgp_pin_model

// ==== mgp_pkg.sv ====
package mgp_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_ADDR_LO_DATA  = 8'h00;
  localparam logic [7:0] OFS_ADDR_HI_DATA  = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO_DIR   = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI_DIR   = 8'h0C;
  localparam logic [7:0] OFS_BUS_DATA      = 8'h10;
  localparam logic [7:0] OFS_BUS_DIR       = 8'h14;
  localparam logic [7:0] OFS_PIN_FUNC      = 8'h18;
  localparam logic [7:0] OFS_PULL_EN       = 8'h1C;
  localparam logic [7:0] OFS_REDUCED       = 8'h20;
  localparam logic [7:0] OFS_WAKE1_DATA    = 8'h24;
  localparam logic [7:0] OFS_WAKE1_DIR     = 8'h28;
  localparam logic [7:0] OFS_WAKE1_FLAGS   = 8'h2C;
  localparam logic [7:0] OFS_WAKE1_IEN     = 8'h30;
  localparam logic [7:0] OFS_WAKE2_DATA    = 8'h34;
  localparam logic [7:0] OFS_WAKE2_DIR     = 8'h38;
  localparam logic [7:0] OFS_WAKE2_FLAGS   = 8'h3C;
  localparam logic [7:0] OFS_WAKE2_IEN     = 8'h40;
  localparam logic [7:0] OFS_PWM_DATA      = 8'h44;
  localparam logic [7:0] OFS_PWM_DIR       = 8'h48;
  localparam logic [7:0] OFS_PWM_CTRL      = 8'h4C;
  localparam logic [7:0] OFS_CAN_DATA      = 8'h50;
  localparam logic [7:0] OFS_AN0_DATA      = 8'h54;
  localparam logic [7:0] OFS_AN1_DATA      = 8'h58;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int PULL_BIT_ADDR_LO  = 0;
  localparam int PULL_BIT_ADDR_HI  = 1;
  localparam int PULL_BIT_BUS_CTRL = 4;
  localparam int PULL_BIT_WAKE_ONE = 5;
  localparam int PULL_BIT_WAKE_TWO = 6;
  localparam int DRV_BIT_ADDR_LO   = 0;
  localparam int DRV_BIT_ADDR_HI   = 1;
  localparam int DRV_BIT_BUS_CTRL  = 4;
  localparam int DRV_BIT_WAKE_ONE  = 5;
  localparam int DRV_BIT_WAKE_TWO  = 6;
  localparam int PWMC_BIT_PULL     = 0;
  localparam int PWMC_BIT_DRIVE    = 1;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] BUS_CTRL_DIR_MASK = 8'hFC;
  localparam logic [7:0] BUS_CTRL_PULL_MASK = 8'h8F;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [1:0] {
    MGP_SINGLE_CHIP,
    MGP_EXPANDED,
    MGP_PERIPHERAL
  } mgp_mode_t;
endpackage : mgp_pkg
